// [coarse_mixer.v]
// Coarse quadrature mixer that walks a 2, 4 or 8 sample sequence.
`timescale 1ns/10ps
`include "interp_mixer_map.vh"
module coarse_mixer (
  input wire core_clk,
  input wire rst_b,
  input wire [2:0] mode,
  input wire in_valid,
  input wire signed [15:0] in_i,
  input wire signed [15:0] in_q,
  output reg out_valid,
  output reg signed [15:0] out_i,
  output reg signed [15:0] out_q
);
  reg [2:0] idx_q;
  reg [2:0] last_d;
  wire signed [17:0] sum = {{2{in_i[15]}}, in_i} + {{2{in_q[15]}}, in_q};
  wire signed [17:0] dif = {{2{in_i[15]}}, in_i} - {{2{in_q[15]}}, in_q};
  wire signed [35:0] rs_full = sum * `MAP_ROOT_HALF;
  wire signed [35:0] rd_full = dif * `MAP_ROOT_HALF;
  wire signed [15:0] rs = rs_full[30:15]; // r(I+Q)
  wire signed [15:0] rd = rd_full[30:15]; // r(I-Q)

  // Last index of the sequence for the selected mode.
  always @* begin
    case (mode)
      `MAP_MOD_HALF: last_d = 3'h1;
      `MAP_MOD_QUARTER: last_d = 3'h3;
      `MAP_MOD_THREEQ: last_d = 3'h3;
      `MAP_MOD_EIGHTH: last_d = 3'h7;
      default: last_d = 3'h0;
    endcase
  end

  // Index advances once per sample and wraps at the sequence length.
  always @(posedge core_clk) begin
    if (!rst_b || mode == `MAP_MOD_OFF) begin
      idx_q <= 3'h0;
    end else if (in_valid) begin
      idx_q <= (idx_q >= last_d) ? 3'h0 : idx_q + 3'h1;
    end
  end

  // Products of the input with the carrier; negation wraps at full scale.
  always @(posedge core_clk) begin
    if (!rst_b) begin
      out_valid <= 1'b0;
      out_i <= 16'sh0000;
      out_q <= 16'sh0000;
    end else begin
      out_valid <= in_valid;
      out_i <= in_i;
      out_q <= in_q;
      case (mode)
        `MAP_MOD_HALF: begin
          out_i <= idx_q[0] ? -in_i : in_i;
          out_q <= idx_q[0] ? -in_q : in_q;
        end
        `MAP_MOD_QUARTER: begin
          case (idx_q[1:0])
            2'h0: begin out_i <= in_i; out_q <= in_q; end
            2'h1: begin out_i <= in_q; out_q <= -in_i; end
            2'h2: begin out_i <= -in_i; out_q <= -in_q; end
            default: begin out_i <= -in_q; out_q <= in_i; end
          endcase
        end
        `MAP_MOD_THREEQ: begin
          case (idx_q[1:0])
            2'h0: begin out_i <= in_i; out_q <= in_q; end
            2'h1: begin out_i <= -in_q; out_q <= in_i; end
            2'h2: begin out_i <= -in_i; out_q <= -in_q; end
            default: begin out_i <= in_q; out_q <= -in_i; end
          endcase
        end
        `MAP_MOD_EIGHTH: begin
          case (idx_q)
            3'h0: begin out_i <= in_i; out_q <= in_q; end
            3'h1: begin out_i <= rs; out_q <= -rd; end
            3'h2: begin out_i <= in_q; out_q <= -in_i; end
            3'h3: begin out_i <= -rd; out_q <= -rs; end
            3'h4: begin out_i <= -in_i; out_q <= -in_q; end
            3'h5: begin out_i <= -rs; out_q <= rd; end
            3'h6: begin out_i <= -in_q; out_q <= in_i; end
            default: begin out_i <= rd; out_q <= rs; end
          endcase
        end
        default: begin
          out_i <= in_i;
          out_q <= in_q;
        end
      endcase
    end
  end
endmodule // coarse_mixer

// [datapath_monitor.sv]
// Checker for the register handshake and the output timing of the datapath.
`timescale 1ns/10ps
module datapath_monitor (
  input logic core_clk,
  input logic rst_b,
  input logic [7:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [31:0] avs_readdata,
  input logic avs_waitrequest,
  input logic sample_valid,
  input logic dac_valid,
  input logic [15:0] dac_i,
  input logic [15:0] dac_q,
  input logic [31:0] phase_word
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic [5:0] idle_q;
  logic [5:0] idle_d;
  // Counts cycles since the last sample bus transfer and saturates.
  assign idle_d = sample_valid ? 6'h00 : (idle_q == 6'h3f ? idle_q : idle_q + 6'h01);
  // Registers the idle count.
  always @(posedge core_clk) begin
    if (!rst_b) begin
      idle_q <= 6'h00;
    end else begin
      idle_q <= idle_d;
    end
  end
  a_wait_drop: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest did not drop after a request");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest stayed low");
  a_wait_cause: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
    else $error("waitrequest dropped without a request");
  a_rdata_hold: assert property ($changed(avs_readdata) |-> $past(avs_read && avs_waitrequest))
    else $error("read data changed outside a read");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 8'h17
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  a_dac_hold: assert property (!dac_valid |-> $stable(dac_i) && $stable(dac_q))
    else $error("output sample moved without valid");
  a_dac_idle: assert property (idle_q > 6'd24 |-> !dac_valid)
    else $error("output sample without input");
  a_phase_idle: assert property (idle_q > 6'd24 |-> $stable(phase_word))
    else $error("phase moved without samples");
endmodule // datapath_monitor

bind interpolation_coarse_mixer datapath_monitor i_datapath_monitor (
  .core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .sample_valid(sample_valid), .dac_valid(dac_valid), .dac_i(dac_i), .dac_q(dac_q),
  .phase_word(phase_word));

// [halfband_stage.v]
// One 2x interpolation stage: doubles the sample rate or passes samples through.
`timescale 1ns/10ps
module halfband_stage #(
  parameter W = 16
) (
  input wire core_clk,
  input wire rst_b,
  input wire enable,
  input wire in_valid,
  input wire signed [W-1:0] in_i,
  input wire signed [W-1:0] in_q,
  output reg out_valid,
  output reg signed [W-1:0] out_i,
  output reg signed [W-1:0] out_q
);
  reg signed [W-1:0] prev_i_q;
  reg signed [W-1:0] prev_q_q;
  reg pend_q;
  // Inputs that arrive while the second output of an earlier sample is due, or behind queued ones, wait here.
  reg signed [W-1:0] fifo_i_q [0:3];
  reg signed [W-1:0] fifo_q_q [0:3];
  reg [2:0] cnt_q;
  reg [1:0] rd_q;
  reg [1:0] wr_q;
  wire from_fifo = (cnt_q != 3'h0);
  wire signed [W-1:0] head_i = from_fifo ? fifo_i_q[rd_q] : in_i;
  wire signed [W-1:0] head_q = from_fifo ? fifo_q_q[rd_q] : in_q;
  wire pop = !pend_q && (from_fifo || in_valid);
  wire push = in_valid && (pend_q || from_fifo);
  wire take_fifo = pop && from_fifo;
  wire signed [W:0] mid_i = ({head_i[W-1], head_i} + {prev_i_q[W-1], prev_i_q}) >>> 1;
  wire signed [W:0] mid_q = ({head_q[W-1], head_q} + {prev_q_q[W-1], prev_q_q}) >>> 1;

  // Each sample yields the midpoint to the last one, then itself; bursts queue up.
  always @(posedge core_clk) begin
    if (!rst_b) begin
      prev_i_q <= {W{1'b0}};
      prev_q_q <= {W{1'b0}};
      pend_q <= 1'b0;
      cnt_q <= 3'h0;
      rd_q <= 2'h0;
      wr_q <= 2'h0;
      out_valid <= 1'b0;
      out_i <= {W{1'b0}};
      out_q <= {W{1'b0}};
    end else if (enable) begin
      if (push) begin
        fifo_i_q[wr_q] <= in_i;
        fifo_q_q[wr_q] <= in_q;
        wr_q <= wr_q + 2'h1;
      end
      if (take_fifo) begin
        rd_q <= rd_q + 2'h1;
      end
      if (push && !take_fifo) begin
        cnt_q <= cnt_q + 3'h1;
      end else if (take_fifo && !push) begin
        cnt_q <= cnt_q - 3'h1;
      end
      if (pend_q) begin
        out_i <= prev_i_q;
        out_q <= prev_q_q;
        out_valid <= 1'b1;
        pend_q <= 1'b0;
      end else if (pop) begin
        out_i <= mid_i[W-1:0];
        out_q <= mid_q[W-1:0];
        out_valid <= 1'b1;
        prev_i_q <= head_i;
        prev_q_q <= head_q;
        pend_q <= 1'b1;
      end else begin
        out_valid <= 1'b0;
      end
    end else begin
      out_valid <= in_valid;
      out_i <= in_i;
      out_q <= in_q;
      pend_q <= 1'b0;
      cnt_q <= 3'h0;
      rd_q <= 2'h0;
      wr_q <= 2'h0;
    end
  end
endmodule // halfband_stage

// [interp_mixer_map.vh]
// Register offsets, field positions, reset values and mixing constants of the datapath.
`ifndef INTERP_MIXER_MAP_VH
`define INTERP_MIXER_MAP_VH

// Byte offsets of the registers on the Avalon-MM slave.
`define MAP_CTRL_OFS 8'h00
`define MAP_TUNE_OFS 8'h04
`define MAP_UPDATE_OFS 8'h08
`define MAP_STATUS_OFS 8'h0c
`define MAP_PHASE_OFS 8'h10
`define MAP_ACTIVE_OFS 8'h14

// Field positions inside the control register.
`define MAP_CTRL_WIDTH_LSB 0
`define MAP_CTRL_HB1_BIT 2
`define MAP_CTRL_HB2_BIT 3
`define MAP_CTRL_HB3_BIT 4
`define MAP_CTRL_MODE_LSB 5
`define MAP_CTRL_STAGE_LSB 8
`define MAP_CTRL_PREMOD_BIT 10
`define MAP_CTRL_RESET 32'h0000_0000

// Input bus width modes.
`define MAP_WIDTH_BYTE 2'h0
`define MAP_WIDTH_WORD 2'h1
`define MAP_WIDTH_DUAL 2'h2

// Coarse modulation modes.
`define MAP_MOD_OFF 3'h0
`define MAP_MOD_HALF 3'h1
`define MAP_MOD_QUARTER 3'h2
`define MAP_MOD_THREEQ 3'h3
`define MAP_MOD_EIGHTH 3'h4

// Root two over two in Q15.
`define MAP_ROOT_HALF 18'sh05a82

// Real bandwidth in percent of the input sample rate, per first enabled of stages one and two.
`define MAP_BW_HB1 8'h28
`define MAP_BW_HB2 8'h19
`define MAP_BW_NONE 8'h32

`endif

// [interpolation_coarse_mixer.v]
// Transmit datapath: bus assembly, three 2x stages, coarse mixer, tuning word and registers.
//
// Added by the designer: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
`include "interp_mixer_map.vh"
module interpolation_coarse_mixer (
  input wire core_clk,
  input wire rst_b,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire sample_valid,
  input wire [31:0] sample_bus,
  output reg dac_valid,
  output reg [15:0] dac_i,
  output reg [15:0] dac_q,
  output reg [31:0] phase_word
);
  // Software visible state.
  reg [31:0] ctrl_q;
  reg [31:0] tune_q;
  reg update_q;
  reg [31:0] active_q;
  reg [31:0] phase_q;
  reg overrun_q;

  // Bus assembly state.
  reg [1:0] beat_q;
  reg [15:0] hold_i_q;
  reg [7:0] hold_b_q;
  reg [15:0] hold_q_q;
  reg asm_valid_q;
  reg signed [15:0] asm_i_q;
  reg signed [15:0] asm_q_q;

  // Decoded control fields.
  wire [1:0] bus_width = ctrl_q[`MAP_CTRL_WIDTH_LSB+1:`MAP_CTRL_WIDTH_LSB];
  wire hb1_en = ctrl_q[`MAP_CTRL_HB1_BIT];
  wire hb2_en = ctrl_q[`MAP_CTRL_HB2_BIT];
  wire hb3_en = ctrl_q[`MAP_CTRL_HB3_BIT];
  wire [2:0] mod_mode = ctrl_q[`MAP_CTRL_MODE_LSB+2:`MAP_CTRL_MODE_LSB];
  wire [1:0] mod_stage = ctrl_q[`MAP_CTRL_STAGE_LSB+1:`MAP_CTRL_STAGE_LSB];
  wire premod_en = ctrl_q[`MAP_CTRL_PREMOD_BIT];

  // Bus handshake terms.
  wire access = avs_read || avs_write;
  wire take = access && !avs_waitrequest;
  wire [5:0] word_sel = avs_address[7:2];
  wire [31:0] lane_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                           {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // Stage and mixer interconnect.
  wire pre_valid;
  wire signed [15:0] pre_i;
  wire signed [15:0] pre_q;
  wire s1_valid;
  wire signed [15:0] s1_i;
  wire signed [15:0] s1_q;
  wire s2_valid;
  wire signed [15:0] s2_i;
  wire signed [15:0] s2_q;
  wire s3_valid;
  wire signed [15:0] s3_i;
  wire signed [15:0] s3_q;
  wire mix_valid;
  wire signed [15:0] mix_i;
  wire signed [15:0] mix_q;
  reg mx_in_valid;
  reg signed [15:0] mx_in_i;
  reg signed [15:0] mx_in_q;
  reg s2_in_valid;
  reg signed [15:0] s2_in_i;
  reg signed [15:0] s2_in_q;
  reg s3_in_valid;
  reg signed [15:0] s3_in_i;
  reg signed [15:0] s3_in_q;
  reg fin_valid;
  reg signed [15:0] fin_i;
  reg signed [15:0] fin_q;
  reg [7:0] real_bw;
  reg [31:0] rdata_d;
  reg [31:0] ctrl_d;
  reg [31:0] tune_d;

  // Waitrequest drops for one cycle after a request has been seen, then rises again.
  always @(posedge core_clk) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
    end else if (access && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Byte lane merge of the writable registers.
  always @* begin
    ctrl_d = (ctrl_q & ~lane_mask) | (avs_writedata & lane_mask);
    tune_d = (tune_q & ~lane_mask) | (avs_writedata & lane_mask);
  end

  // Register writes take effect on the edge where waitrequest is seen low.
  always @(posedge core_clk) begin
    if (!rst_b) begin
      ctrl_q <= `MAP_CTRL_RESET;
      tune_q <= 32'h0000_0000;
      update_q <= 1'b0;
    end else if (take && avs_write) begin
      case (word_sel)
        `MAP_CTRL_OFS >> 2: ctrl_q <= {21'h000000, ctrl_d[10:0]};
        `MAP_TUNE_OFS >> 2: tune_q <= tune_d;
        `MAP_UPDATE_OFS >> 2: begin
          if (avs_byteenable[0]) begin
            update_q <= avs_writedata[0];
          end
        end
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  // The active word only follows the written word on a 0 to 1 step of the update bit.
  always @(posedge core_clk) begin
    if (!rst_b) begin
      active_q <= 32'h0000_0000;
    end else if (take && avs_write && word_sel == (`MAP_UPDATE_OFS >> 2) &&
                 avs_byteenable[0] && avs_writedata[0] && !update_q) begin
      active_q <= tune_q;
    end
  end

  // Phase accumulates the active word once per first stage output sample.
  always @(posedge core_clk) begin
    if (!rst_b) begin
      phase_q <= 32'h0000_0000;
    end else if (s1_valid) begin
      phase_q <= phase_q + active_q;
    end
  end

  // Real bandwidth depends on the first enabled of stages one and two; complex is twice that.
  always @* begin
    if (hb1_en) begin
      real_bw = `MAP_BW_HB1;
    end else if (hb2_en) begin
      real_bw = `MAP_BW_HB2;
    end else begin
      real_bw = `MAP_BW_NONE;
    end
  end

  // Read data for each mapped word; unmapped words read as zero.
  always @* begin
    case (word_sel)
      `MAP_CTRL_OFS >> 2: rdata_d = ctrl_q;
      `MAP_TUNE_OFS >> 2: rdata_d = tune_q;
      `MAP_UPDATE_OFS >> 2: rdata_d = {31'h00000000, update_q};
      `MAP_STATUS_OFS >> 2: rdata_d = {7'h00, overrun_q, real_bw << 1, real_bw,
                                       6'h00, beat_q};
      `MAP_PHASE_OFS >> 2: rdata_d = phase_q;
      `MAP_ACTIVE_OFS >> 2: rdata_d = active_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // Read data is loaded as waitrequest falls and stands while it is low.
  always @(posedge core_clk) begin
    if (!rst_b) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= rdata_d;
    end
  end

  // Bus transfers assemble into I/Q pairs: four bytes, two words or one dual word.
  always @(posedge core_clk) begin
    if (!rst_b) begin
      beat_q <= 2'h0;
      hold_i_q <= 16'h0000;
      hold_b_q <= 8'h00;
      hold_q_q <= 16'h0000;
      asm_valid_q <= 1'b0;
      asm_i_q <= 16'sh0000;
      asm_q_q <= 16'sh0000;
    end else begin
      asm_valid_q <= 1'b0;
      if (sample_valid) begin
        case (bus_width)
          `MAP_WIDTH_DUAL: begin
            asm_i_q <= sample_bus[31:16];
            asm_q_q <= sample_bus[15:0];
            asm_valid_q <= 1'b1;
            beat_q <= 2'h0;
          end
          `MAP_WIDTH_WORD: begin
            if (beat_q[0]) begin
              asm_i_q <= hold_i_q;
              asm_q_q <= sample_bus[15:0];
              asm_valid_q <= 1'b1;
              beat_q <= 2'h0;
            end else begin
              hold_i_q <= sample_bus[15:0];
              beat_q <= 2'h1;
            end
          end
          `MAP_WIDTH_BYTE: begin
            case (beat_q)
              2'h0: hold_b_q <= sample_bus[7:0];
              2'h1: hold_i_q <= {hold_b_q, sample_bus[7:0]};
              2'h2: hold_b_q <= sample_bus[7:0];
              default: begin
                asm_i_q <= hold_i_q;
                asm_q_q <= {hold_b_q, sample_bus[7:0]};
                asm_valid_q <= 1'b1;
              end
            endcase
            beat_q <= beat_q + 2'h1;
          end
          default: beat_q <= 2'h0;
        endcase
      end
    end
  end

  // Premodulation shifts by half the input rate ahead of the first stage.
  coarse_mixer premod (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .mode(premod_en ? `MAP_MOD_HALF : `MAP_MOD_OFF),
    .in_valid(asm_valid_q),
    .in_i(asm_i_q),
    .in_q(asm_q_q),
    .out_valid(pre_valid),
    .out_i(pre_i),
    .out_q(pre_q)
  );

  // First 2x stage.
  halfband_stage #(.W(16)) stage1 (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .enable(hb1_en),
    .in_valid(pre_valid),
    .in_i(pre_i),
    .in_q(pre_q),
    .out_valid(s1_valid),
    .out_i(s1_i),
    .out_q(s1_q)
  );

  // The coarse mixer sits behind the stage picked by software.
  always @* begin
    case (mod_stage)
      2'h0: begin
        mx_in_valid = s1_valid;
        mx_in_i = s1_i;
        mx_in_q = s1_q;
      end
      2'h1: begin
        mx_in_valid = s2_valid;
        mx_in_i = s2_i;
        mx_in_q = s2_q;
      end
      default: begin
        mx_in_valid = s3_valid;
        mx_in_i = s3_i;
        mx_in_q = s3_q;
      end
    endcase
  end

  // Later stages take the mixer output when it sits in front of them.
  always @* begin
    s2_in_valid = (mod_stage == 2'h0) ? mix_valid : s1_valid;
    s2_in_i = (mod_stage == 2'h0) ? mix_i : s1_i;
    s2_in_q = (mod_stage == 2'h0) ? mix_q : s1_q;
    s3_in_valid = (mod_stage == 2'h1) ? mix_valid : s2_valid;
    s3_in_i = (mod_stage == 2'h1) ? mix_i : s2_i;
    s3_in_q = (mod_stage == 2'h1) ? mix_q : s2_q;
    fin_valid = (mod_stage >= 2'h2) ? mix_valid : s3_valid;
    fin_i = (mod_stage >= 2'h2) ? mix_i : s3_i;
    fin_q = (mod_stage >= 2'h2) ? mix_q : s3_q;
  end

  // Main coarse mixer shifting by a fraction of the input rate.
  coarse_mixer mixer (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .mode(mod_mode),
    .in_valid(mx_in_valid),
    .in_i(mx_in_i),
    .in_q(mx_in_q),
    .out_valid(mix_valid),
    .out_i(mix_i),
    .out_q(mix_q)
  );

  // Second 2x stage.
  halfband_stage #(.W(16)) stage2 (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .enable(hb2_en),
    .in_valid(s2_in_valid),
    .in_i(s2_in_i),
    .in_q(s2_in_q),
    .out_valid(s2_valid),
    .out_i(s2_i),
    .out_q(s2_q)
  );

  // Third 2x stage.
  halfband_stage #(.W(16)) stage3 (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .enable(hb3_en),
    .in_valid(s3_in_valid),
    .in_i(s3_in_i),
    .in_q(s3_in_q),
    .out_valid(s3_valid),
    .out_i(s3_i),
    .out_q(s3_q)
  );

  // A bus transfer in the cycle after a byte or word pair completes marks an overrun.
  always @(posedge core_clk) begin
    if (!rst_b) begin
      overrun_q <= 1'b0;
    end else if (sample_valid && asm_valid_q && bus_width != `MAP_WIDTH_DUAL) begin
      overrun_q <= 1'b1;
    end else if (take && avs_write && word_sel == (`MAP_STATUS_OFS >> 2)) begin
      overrun_q <= 1'b0;
    end
  end

  // Converter samples and phase leave straight from flip-flops.
  always @(posedge core_clk) begin
    if (!rst_b) begin
      dac_valid <= 1'b0;
      dac_i <= 16'h0000;
      dac_q <= 16'h0000;
      phase_word <= 32'h0000_0000;
    end else begin
      dac_valid <= fin_valid;
      if (fin_valid) begin
        dac_i <= fin_i;
        dac_q <= fin_q;
      end
      phase_word <= phase_q;
    end
  end
endmodule // interpolation_coarse_mixer

// [sample_host.sv]
// Host model that drives I/Q pairs onto the sample bus.
`timescale 1ns/10ps
`include "interp_mixer_map.vh"
module sample_host (
  input logic core_clk,
  output logic sample_valid,
  output logic [31:0] sample_bus
);
  // Keeps the bus idle at time zero.
  initial begin
    sample_valid = 1'b0;
    sample_bus = 32'h0;
  end
  // Sends one pair as 4, 2 or 1 transfers, then idles for gap cycles.
  task automatic send(input logic [1:0] w, input logic [15:0] i, input logic [15:0] q,
      input integer gap);
    logic [31:0] beat [0:3];
    integer n;
    integer k;
    n = (w == `MAP_WIDTH_BYTE) ? 4 : (w == `MAP_WIDTH_WORD) ? 2 : 1;
    beat[0] = n == 4 ? {24'h0, i[15:8]} : n == 2 ? {16'h0, i} : {i, q};
    beat[1] = n == 4 ? {24'h0, i[7:0]} : {16'h0, q};
    beat[2] = {24'h0, q[15:8]};
    beat[3] = {24'h0, q[7:0]};
    for (k = 0; k < n; k++) begin
      @(posedge core_clk);
      sample_valid <= 1'b1;
      sample_bus <= beat[k];
    end
    @(posedge core_clk);
    sample_valid <= 1'b0;
    sample_bus <= ~beat[n - 1];
    repeat (gap) @(posedge core_clk);
  endtask
endmodule // sample_host

// [test_interpolation_coarse_mixer.sv]
// Self-checking bench for the transmit datapath.
`timescale 1ns/10ps
`include "interp_mixer_map.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module test_interpolation_coarse_mixer;
  logic core_clk, rst_b, avs_read, avs_write, avs_waitrequest, sample_valid, dac_valid;
  logic [7:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, sample_bus, phase_word, rd, p0;
  logic [15:0] dac_i, dac_q, ei, eq, mi, mq;
  logic [15:0] oi[$];
  logic [15:0] oq[$];
  integer failures, cmp_count, m, k;
  interpolation_coarse_mixer i_interpolation_coarse_mixer (.core_clk(core_clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sample_valid(sample_valid), .sample_bus(sample_bus), .dac_valid(dac_valid),
    .dac_i(dac_i), .dac_q(dac_q), .phase_word(phase_word));
  sample_host i_sample_host (.core_clk(core_clk), .sample_valid(sample_valid),
    .sample_bus(sample_bus));
  // Makes the 20 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Captures every output sample.
  always @(posedge core_clk) begin
    if (dac_valid === 1'b1) begin
      oi.push_back(dac_i);
      oq.push_back(dac_q);
    end
  end
  // Prints the counts and the verdict, then ends the run.
  task report_and_stop;
    $display("failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // One Avalon transfer: holds the request until waitrequest is sampled low.
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer n;
    @(posedge core_clk);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      failures++;
      $display("unexpected at %0t: bus hang", $time);
      report_and_stop;
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  // Waits, bounded, until n output samples have arrived.
  task wait_out(input integer n);
    integer t;
    t = 0;
    while (oi.size() < n && t < 400) begin
      @(posedge core_clk);
      t++;
    end
    if (oi.size() < n) begin
      failures++;
      $display("unexpected at %0t: output timeout", $time);
      report_and_stop;
    end
  endtask
  function automatic logic [31:0] ctl(input logic [1:0] w, input logic [2:0] st,
      input logic [2:0] md, input logic pm);
    ctl = (w << `MAP_CTRL_WIDTH_LSB) | (st << `MAP_CTRL_HB1_BIT) | (md << `MAP_CTRL_MODE_LSB)
      | (pm << `MAP_CTRL_PREMOD_BIT);
  endfunction
  function automatic integer rr(input integer x);
    rr = (x * `MAP_ROOT_HALF) >>> 15;
  endfunction
  // Expected mixer output for mode md at sequence step s.
  task automatic mix_exp(input integer md, input integer s, input integer i, input integer q);
    integer a[0:7];
    integer b[0:7];
    case (md)
      0: begin a = '{8{i}}; b = '{8{q}}; end
      1: begin a = '{i, -i, i, -i, i, -i, i, -i}; b = '{q, -q, q, -q, q, -q, q, -q}; end
      2: begin a = '{i, q, -i, -q, i, q, -i, -q}; b = '{q, -i, -q, i, q, -i, -q, i}; end
      3: begin a = '{i, -q, -i, q, i, -q, -i, q}; b = '{q, i, -q, -i, q, i, -q, -i}; end
      default: begin
        a = '{i, rr(i + q), q, rr(q - i), -i, -rr(i + q), -q, rr(i - q)};
        b = '{q, rr(q - i), -i, -rr(q + i), -q, rr(i - q), i, rr(q + i)};
      end
    endcase
    ei = a[s % 8];
    eq = b[s % 8];
  endtask
  task stat_chk(input logic [2:0] st, input logic [7:0] bw);
    wr(`MAP_CTRL_OFS, ctl(`MAP_WIDTH_DUAL, st, 3'h0, 1'b0));
    bus(1'b0, `MAP_STATUS_OFS, 32'h0);
    `CHK(rd[23:8], {bw << 1, bw})
  endtask
  // Main sequence.
  initial begin
    failures = 0;
    cmp_count = 0;
    rst_b = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    rdchk(`MAP_CTRL_OFS, `MAP_CTRL_RESET);
    rdchk(`MAP_PHASE_OFS, 32'h0);
    wr(8'h18, 32'hffff_ffff);
    rdchk(8'h18, 32'h0);
    wr(`MAP_CTRL_OFS, 32'hffff_ffff);
    rdchk(`MAP_CTRL_OFS, 32'h0000_07ff);
    // New tuning words wait for a rising update bit.
    wr(`MAP_TUNE_OFS, 32'h1234_5678);
    rdchk(`MAP_ACTIVE_OFS, 32'h0);
    wr(`MAP_UPDATE_OFS, 32'h1);
    rdchk(`MAP_ACTIVE_OFS, 32'h1234_5678);
    wr(`MAP_TUNE_OFS, 32'h1999_999a);
    wr(`MAP_UPDATE_OFS, 32'h1);
    rdchk(`MAP_ACTIVE_OFS, 32'h1234_5678);
    wr(`MAP_UPDATE_OFS, 32'h0);
    wr(`MAP_UPDATE_OFS, 32'h1);
    rdchk(`MAP_ACTIVE_OFS, 32'h1999_999a);
    stat_chk(3'h1, `MAP_BW_HB1);
    stat_chk(3'h2, `MAP_BW_HB2);
    stat_chk(3'h0, `MAP_BW_NONE);
    // Phase advances once per first-stage output sample.
    for (m = 0; m < 2; m++) begin
      wr(`MAP_CTRL_OFS, ctl(`MAP_WIDTH_DUAL, m == 0 ? 3'h1 : 3'h0, 3'h0, m == 0));
      p0 = phase_word;
      oi.delete();
      for (k = 0; k < 3; k++) i_sample_host.send(`MAP_WIDTH_DUAL, 16'h0100, 16'h0100, 3);
      wait_out(m == 0 ? 6 : 3);
      repeat (8) @(posedge core_clk);
      `CHK(phase_word - p0, 32'((m == 0 ? 6 : 3) * 32'h1999_999a))
      `CHK(oi.size(), m == 0 ? 6 : 3)
    end
    // Byte and word buses assemble a whole pair.
    for (m = 0; m < 2; m++) begin
      wr(`MAP_CTRL_OFS, ctl(m[1:0], 3'h0, 3'h0, 1'b0));
      oi.delete();
      oq.delete();
      i_sample_host.send(m[1:0], 16'h1234, 16'h5678, 2);
      wait_out(1);
      `CHK(oi[0], 16'h1234)
      `CHK(oq[0], 16'h5678)
    end
    // Each coarse mode over eight steps; mode zero first restarts the index.
    for (m = 0; m < 5; m++) begin
      wr(`MAP_CTRL_OFS, ctl(`MAP_WIDTH_DUAL, 3'h0, 3'h0, 1'b0));
      wr(`MAP_CTRL_OFS, ctl(`MAP_WIDTH_DUAL, 3'h0, m[2:0], 1'b0));
      mi = m < 4 ? 16'h1000 : 16'h2000;
      mq = m < 4 ? 16'h0800 : 16'h2000;
      oi.delete();
      oq.delete();
      for (k = 0; k < 8; k++) i_sample_host.send(`MAP_WIDTH_DUAL, mi, mq, 1);
      wait_out(8);
      for (k = 0; k < 8; k++) begin
        mix_exp(m, k, $signed(mi), $signed(mq));
        `CHK(oi[k], ei)
        `CHK(oq[k], eq)
      end
    end
    // All three stages give eight outputs per input.
    wr(`MAP_CTRL_OFS, ctl(`MAP_WIDTH_DUAL, 3'h7, 3'h0, 1'b0));
    oi.delete();
    oq.delete();
    for (k = 0; k < 4; k++) i_sample_host.send(`MAP_WIDTH_DUAL, 16'h0400, 16'h0200, 7);
    wait_out(32);
    repeat (30) @(posedge core_clk);
    `CHK(oi.size(), 32)
    `CHK(oi[31], 16'h0400)
    report_and_stop;
  end
endmodule // test_interpolation_coarse_mixer
